// ===== bench/plac_master.sv
// axi4-lite master standing for processor and debugger
`timescale 1ns/1ns
`default_nettype none
module plac_master (
    input  wire logic        aclk,     // clock
    output logic             awvalid,  // aw valid
    input  wire logic        awready,  // aw ready
    output logic [7:0]       awaddr,   // aw address
    output logic [2:0]       awprot,   // aw prot
    output logic             aw_debug, // debugger write
    output logic             wvalid,   // w valid
    input  wire logic        wready,   // w ready
    output logic [31:0]      wdata,    // w data
    output logic [3:0]       wstrb,    // w strobes
    input  wire logic        bvalid,   // b valid
    output logic             bready,   // b ready
    input  wire logic [1:0]  bresp,    // b response
    output logic             arvalid,  // ar valid
    input  wire logic        arready,  // ar ready
    output logic [7:0]       araddr,   // ar address
    output logic [2:0]       arprot,   // ar prot
    input  wire logic        rvalid,   // r valid
    output logic             rready,   // r ready
    input  wire logic [31:0] rdata,    // r data
    input  wire logic [1:0]  rresp     // r response
);
    bit tmo;
    initial begin
        {awvalid, aw_debug, wvalid, bready, arvalid, rready, tmo} = '0;
        {awaddr, awprot, wdata, wstrb, araddr, arprot} = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic dbg, ns,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        awvalid  <= 1'b1;
        awaddr   <= a;
        awprot   <= {1'b0, ns, 1'b0};
        aw_debug <= dbg;
        wvalid   <= 1'b1;
        wdata    <= d;
        wstrb    <= 4'hF;
        bready   <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid  <= 1'b0;
                awaddr   <= ~a;
                aw_debug <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
            if (bvalid) break;
        end
        tmo |= (n == 64);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic ns, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        arprot  <= {1'b0, ns, 1'b0};
        rready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
            if (rvalid) break;
        end
        tmo |= (n == 64);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : plac_master
`default_nettype wire

// ===== bench/plac_top_asserts.sv
// concurrent checks on the performance level controller ports
`timescale 1ns/1ns
`default_nettype none
module plac_top_asserts #(
    parameter int unsigned CNT_W     = 16,
    parameter int unsigned TRANS_CYC = 4
) (
    input wire logic        aclk,        // clock
    input wire logic        aresetn,     // reset
    input wire logic        awvalid,     // aw valid
    input wire logic        awready,     // aw ready
    input wire logic [7:0]  awaddr,      // aw address
    input wire logic        aw_debug,    // debugger write
    input wire logic        wvalid,      // w valid
    input wire logic        wready,      // w ready
    input wire logic [31:0] wdata,       // w data
    input wire logic [3:0]  wstrb,       // w strobes
    input wire logic        arvalid,     // ar valid
    input wire logic        arready,     // ar ready
    input wire logic [2:0]  arprot,      // ar prot
    input wire logic        rvalid,      // r valid
    input wire logic [31:0] rdata,       // r data
    input wire logic        secure_attr, // secure block
    input wire logic        write_lock,  // lock
    input wire logic        access_error, // drop pulse
    input wire logic        irq,         // interrupt
    input wire logic        perf_level,  // level
    input wire logic        level_busy   // transition
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] busy_q;
    logic [5:0]  aw_idx_q;
    wire         rd_drop = arvalid && arready && secure_attr && arprot[1];
    wire  [5:0]  wr_idx  = (awvalid && awready) ? awaddr[7:2] : aw_idx_q;
    wire         w1c     = wvalid && wready && wr_idx == 6'h06 && wdata[0] && wstrb[0];
    always_ff @(posedge aclk) begin
        busy_q <= (aresetn && level_busy) ? busy_q + 16'h1 : 16'h0;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_idx_q <= 6'h00;
        end else if (awvalid && awready) begin
            aw_idx_q <= awaddr[7:2];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    drop_error_a: assert property (rd_drop |=> access_error)
        else $error("no error pulse on dropped read");
    drop_zero_a: assert property (rd_drop |=> rvalid && rdata == 32'h0)
        else $error("dropped read not zero");
    open_noerr_a: assert property (!$past(secure_attr) |-> !access_error)
        else $error("error pulse while non-secure");
    busy_noirq_a: assert property (level_busy && $past(level_busy) |-> !irq)
        else $error("interrupt during transition");
    trans_len_a: assert property ($fell(level_busy) |-> busy_q >= TRANS_CYC)
        else $error("transition too short");
    level_moves_a: assert property ($changed(perf_level) |-> $fell(level_busy))
        else $error("level changed outside transition end");
    reset_level_a: assert property ($rose(aresetn) |-> !perf_level && !irq)
        else $error("not at level zero after reset");
    clear_irq_a: assert property (w1c && !level_busy |-> ##[1:4] !irq)
        else $error("interrupt kept after flag clear");
    cover property (rd_drop);
    cover property ($fell(level_busy) ##2 irq);
    cover property (write_lock && aw_debug && awvalid && awready);
endmodule : plac_top_asserts
`default_nettype wire
bind plac_top plac_top_asserts #(.CNT_W(CNT_W), .TRANS_CYC(TRANS_CYC)) chk (.aclk, .aresetn,
    .awvalid, .awready, .awaddr, .aw_debug, .wvalid, .wready, .wdata, .wstrb, .arvalid,
    .arready, .arprot, .rvalid, .rdata, .secure_attr, .write_lock, .access_error, .irq,
    .perf_level, .level_busy);

// ===== bench/tb_plac_top.sv
// self-checking bench of the performance level controller
`timescale 1ns/1ns
`default_nettype none
module tb_plac_top;
    localparam int TC = 4;
    logic aclk = 0, aresetn = 0, secure_attr = 0, write_lock = 0;
    logic awvalid, awready, aw_debug, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, access_error, irq, perf_level, level_busy;
    logic [7:0]  awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] wdata, rdata, dat, rnd = 32'h7EEDFFFC;
    logic [7:0]  ix [5] = '{8'h08, 8'h10, 8'h14, 8'h18, 8'h1C};
    int miscompares = 0, comparisons = 0, errs = 0, lvl = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (access_error === 1'b1) errs++;
    plac_top #(.TRANS_CYC(TC)) dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot,
        .aw_debug, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .secure_attr,
        .write_lock, .access_error, .irq, .perf_level, .level_busy);
    plac_master m (.aclk, .awvalid, .awready, .awaddr, .awprot, .aw_debug, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
        .rvalid, .rready, .rdata, .rresp);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic results();
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp || m.tmo) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
        if (m.tmo) results();
    endtask : chk
    task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic dbg, ns,
                      input logic [1:0] er);
        m.wr(a, d, dbg, ns, rsp);
        rnd = lfsr(rnd);
        #1;
        chk(rsp, er);
    endtask : wc
    task automatic rc(input logic [7:0] a, input logic ns, input logic [31:0] e,
                      input logic [1:0] er);
        m.rd(a, ns, dat, rsp);
        chk(dat, e);
        chk(rsp, er);
    endtask : rc
    task automatic settle();
        int n;
        for (n = 0; n < 50 && level_busy !== 1'b0; n++) @(posedge aclk);
        @(posedge aclk);
        #1;
        chk(32'(n < 50), 1);
        if (n >= 50) results();
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ix[i]) rc(ix[i], 0, 0, 0);
        rc(8'h00, 0, 0, 2);
        wc(8'h40, rnd, 0, 0, 2);
        wc(8'h14, 1, 0, 0, 0);
        rc(8'h10, 0, 1, 0);
        repeat (4) begin
            dat = rnd;
            lvl = int'(dat[0]);
            wc(8'h08, dat, 0, dat[1], 0);
            chk({level_busy, irq}, 2'b10);
            settle();
            chk({perf_level, irq}, {dat[0], 1'b1});
            rc(8'h1C, 0, 32'(lvl), 0);
        end
        write_lock <= 1'b1;
        wc(8'h08, 32'(lvl ^ 1), 0, 0, 0);
        chk({level_busy, irq}, 2'b01);
        wc(8'h18, 1, 0, 0, 0);
        chk(irq, 0);
        wc(8'h08, 32'(lvl ^ 1), 1, 0, 0);
        settle();
        lvl = lvl ^ 1;
        chk({perf_level, irq}, {lvl[0], 1'b1});
        rc(8'h18, 0, 1, 0);
        write_lock <= 1'b0;
        secure_attr <= 1'b1;
        wc(8'h08, 32'(lvl ^ 1), 0, 1, 0);
        chk(level_busy, 0);
        rc(8'h14, 1, 0, 0);
        rc(8'h14, 0, 1, 0);
        chk(errs, 2);
        secure_attr <= 1'b0;
        wc(8'h10, 1, 0, 0, 0);
        rc(8'h14, 0, 0, 0);
        wc(8'h08, 32'(lvl), 0, 0, 0);
        settle();
        chk(irq, 0);
        rc(8'h18, 0, 1, 0);
        results();
    end
endmodule : tb_plac_top
`default_nettype wire

// ===== hdl/plac_cfg.svh
// constants of the performance level access controller
//
// Notes on behaviour
// - A register write is ignored while the access controller write lock is on.
// - The interrupt flag register ignores the write lock and stays writable.
// - Writes marked as debugger accesses pass the write lock.
// - With the block attributed non-secure, secure and non-secure accesses both work.
// - With the block secure, a non-secure access is dropped: no write, zero read, error pulse.
// - Software selects one of exactly two performance levels.
// - Level zero is the most efficient one, with the lower maximum frequency.
// - Bit 0 of the flag register is set when the level is ready and, if enabled, interrupts.
// - Writing one to the ready flag clears it and its interrupt request.
`ifndef PLAC_CFG_SVH
`define PLAC_CFG_SVH

// register indices, byte address is four times the index
`define PLAC_IDX_LEVEL      6'h02
`define PLAC_IDX_EN_CLR     6'h04
`define PLAC_IDX_EN_SET     6'h05
`define PLAC_IDX_FLAG       6'h06
`define PLAC_IDX_STATUS     6'h07

// field positions
`define PLAC_BIT_LEVEL_SEL  0
`define PLAC_BIT_RDY        0
`define PLAC_BIT_ST_LEVEL   0
`define PLAC_BIT_ST_BUSY    1

// reset values
`define PLAC_RST_LEVEL      1'h0
`define PLAC_RST_FLAG       1'h0
`define PLAC_RST_INTEN      1'h0

// response codes
`define PLAC_RESP_OKAY      2'h0
`define PLAC_RESP_SLVERR    2'h2

// voltage transition time
`define PLAC_TRANS_NS       1000
`define PLAC_CLK_MHZ        250
`define PLAC_TRANS_CYC      ((`PLAC_TRANS_NS * `PLAC_CLK_MHZ + 999) / 1000)

`endif

// ===== hdl/plac_pkg.sv
// types of the performance level access controller
package plac_pkg;

    // one captured bus access
    typedef struct packed {
        logic [5:0] idx;
        logic       nonsec;
        logic       debug;
    } plac_req_s;

    // level transition state
    typedef enum logic [1:0] {
        PLAC_ST_STABLE = 2'b01,
        PLAC_ST_SCALE  = 2'b10
    } plac_state_e;

endpackage : plac_pkg

// ===== hdl/plac_top.sv
// performance level controller with protected register access over axi4-lite
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "plac_cfg.svh"

module plac_top #(
    parameter int unsigned CNT_W     = 16,
    parameter int unsigned TRANS_CYC = `PLAC_TRANS_CYC
) (
    input  wire logic        aclk,          // bus clock
    input  wire logic        aresetn,       // sync reset, active low
    input  wire logic        awvalid,       // write address valid
    output logic             awready,       // write address ready
    input  wire logic [7:0]  awaddr,        // write byte address
    input  wire logic [2:0]  awprot,        // bit 1 high: non-secure
    input  wire logic        aw_debug,      // write comes from debugger
    input  wire logic        wvalid,        // write data valid
    output logic             wready,        // write data ready
    input  wire logic [31:0] wdata,         // write data
    input  wire logic [3:0]  wstrb,         // byte enables
    output logic             bvalid,        // write response valid
    input  wire logic        bready,        // write response ready
    output logic [1:0]       bresp,         // write response
    input  wire logic        arvalid,       // read address valid
    output logic             arready,       // read address ready
    input  wire logic [7:0]  araddr,        // read byte address
    input  wire logic [2:0]  arprot,        // bit 1 high: non-secure
    output logic             rvalid,        // read data valid
    input  wire logic        rready,        // read data ready
    output logic [31:0]      rdata,         // read data
    output logic [1:0]       rresp,         // read response
    input  wire logic        secure_attr,   // block attributed secure
    input  wire logic        write_lock,    // access controller write lock
    output logic             access_error,  // dropped access pulse
    output logic             irq,           // level interrupt
    output logic             perf_level,    // active performance level
    output logic             level_busy     // voltage transition running
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic                  awready_q;
    logic                  wready_q;
    logic                  aw_hold_q;
    logic                  w_hold_q;
    plac_pkg::plac_req_s   aw_q;
    logic [31:0]           wdata_q;
    logic                  wstrb0_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  arready_q;
    logic                  rvalid_q;
    logic [31:0]           rdata_q;
    logic [1:0]            rresp_q;
    logic                  access_error_q;
    logic                  irq_q;
    logic                  level_sel_q;
    logic                  level_act_q;
    logic                  flag_q;
    logic                  inten_q;
    plac_pkg::plac_state_e state_q;
    logic [CNT_W-1:0]      cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // write path decode

    plac_pkg::plac_req_s aw_in;
    plac_pkg::plac_req_s ar_in;
    logic                aw_fire;
    logic                w_fire;
    logic                wr_fire;
    logic                wr_drop;
    logic                wr_mapped;
    logic                wr_locked;
    logic                wr_ok;
    logic                wr_level;
    logic                wr_enset;
    logic                wr_enclr;
    logic                wr_flag;

    assign aw_in.idx    = awaddr[7:2];
    assign aw_in.nonsec = awprot[1];
    assign aw_in.debug  = aw_debug;
    assign ar_in.idx    = araddr[7:2];
    assign ar_in.nonsec = arprot[1];
    assign ar_in.debug  = 1'b0;

    assign aw_fire   = awvalid && awready_q;
    assign w_fire    = wvalid && wready_q;
    assign wr_fire   = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_drop   = secure_attr && aw_q.nonsec;
    assign wr_mapped = (aw_q.idx == `PLAC_IDX_LEVEL)
                    || (aw_q.idx == `PLAC_IDX_EN_CLR)
                    || (aw_q.idx == `PLAC_IDX_EN_SET)
                    || (aw_q.idx == `PLAC_IDX_FLAG)
                    || (aw_q.idx == `PLAC_IDX_STATUS);
    // lock never covers the flag register, debugger passes it
    assign wr_locked = write_lock && !aw_q.debug
                    && (aw_q.idx != `PLAC_IDX_FLAG);
    assign wr_ok     = wr_fire && wr_mapped && !wr_drop && !wr_locked && wstrb0_q;

    assign wr_level = wr_ok && (aw_q.idx == `PLAC_IDX_LEVEL);
    assign wr_enset = wr_ok && (aw_q.idx == `PLAC_IDX_EN_SET)
                   && wdata_q[`PLAC_BIT_RDY];
    assign wr_enclr = wr_ok && (aw_q.idx == `PLAC_IDX_EN_CLR)
                   && wdata_q[`PLAC_BIT_RDY];
    assign wr_flag  = wr_ok && (aw_q.idx == `PLAC_IDX_FLAG)
                   && wdata_q[`PLAC_BIT_RDY];

    ////////////////////////////////////////////////////////////////////////////
    // read path decode

    logic        rd_fire;
    logic        rd_drop;
    logic        rd_mapped;
    logic        rd_flag;
    logic [31:0] rd_word;

    assign rd_fire   = arvalid && arready_q;
    assign rd_drop   = secure_attr && ar_in.nonsec;
    assign rd_mapped = (ar_in.idx == `PLAC_IDX_LEVEL)
                    || (ar_in.idx == `PLAC_IDX_EN_CLR)
                    || (ar_in.idx == `PLAC_IDX_EN_SET)
                    || (ar_in.idx == `PLAC_IDX_FLAG)
                    || (ar_in.idx == `PLAC_IDX_STATUS);
    assign rd_flag   = rd_fire && !rd_drop && (ar_in.idx == `PLAC_IDX_FLAG);

    always_comb begin
        rd_word = 32'h0000_0000;
        if (rd_drop) begin
            rd_word = 32'h0000_0000;
        end else if (ar_in.idx == `PLAC_IDX_LEVEL) begin
            rd_word[`PLAC_BIT_LEVEL_SEL] = level_sel_q;
        end else if (ar_in.idx == `PLAC_IDX_EN_CLR) begin
            rd_word[`PLAC_BIT_RDY] = inten_q;
        end else if (ar_in.idx == `PLAC_IDX_EN_SET) begin
            rd_word[`PLAC_BIT_RDY] = inten_q;
        end else if (ar_in.idx == `PLAC_IDX_FLAG) begin
            rd_word[`PLAC_BIT_RDY] = flag_q;
        end else if (ar_in.idx == `PLAC_IDX_STATUS) begin
            rd_word[`PLAC_BIT_ST_LEVEL] = level_act_q;
            rd_word[`PLAC_BIT_ST_BUSY]  = (state_q == plac_pkg::PLAC_ST_SCALE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level transition

    plac_pkg::plac_state_e state_d;
    logic [CNT_W-1:0]      cnt_d;
    logic                  trans_done;

    assign trans_done = (state_q == plac_pkg::PLAC_ST_SCALE)
                     && (cnt_q == CNT_W'(TRANS_CYC - 1)) && !wr_level;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            plac_pkg::PLAC_ST_STABLE: begin
                if (wr_level) begin
                    state_d = plac_pkg::PLAC_ST_SCALE;
                    cnt_d   = '0;
                end
            end
            plac_pkg::PLAC_ST_SCALE: begin
                if (wr_level) begin
                    cnt_d = '0;
                end else if (trans_done) begin
                    state_d = plac_pkg::PLAC_ST_STABLE;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            default: begin
                state_d = plac_pkg::PLAC_ST_STABLE;
                cnt_d   = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag and enable next values

    logic flag_d;
    logic flag_clr;
    logic inten_d;

    // new selection or software clear empties the flag, completion wins
    assign flag_clr = wr_flag || rd_flag || wr_level;
    assign flag_d   = trans_done || (flag_q && !flag_clr);
    assign inten_d  = wr_enset || (inten_q && !wr_enclr);

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_q      <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb0_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `PLAC_RESP_OKAY;
        end else begin
            awready_q <= awvalid && !awready_q && !aw_hold_q && !bvalid_q;
            wready_q  <= wvalid && !wready_q && !w_hold_q && !bvalid_q;
            if (aw_fire) begin
                aw_hold_q <= 1'b1;
                aw_q      <= aw_in;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (w_fire) begin
                w_hold_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb0_q <= wstrb[0];
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_mapped ? `PLAC_RESP_OKAY : `PLAC_RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `PLAC_RESP_OKAY;
        end else begin
            arready_q <= arvalid && !arready_q && !rvalid_q;
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_mapped ? `PLAC_RESP_OKAY : `PLAC_RESP_SLVERR;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // block state registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_sel_q <= `PLAC_RST_LEVEL;
            level_act_q <= `PLAC_RST_LEVEL;
            flag_q      <= `PLAC_RST_FLAG;
            inten_q     <= `PLAC_RST_INTEN;
            state_q     <= plac_pkg::PLAC_ST_STABLE;
            cnt_q       <= '0;
            irq_q       <= 1'b0;
            access_error_q <= 1'b0;
        end else begin
            if (wr_level) begin
                level_sel_q <= wdata_q[`PLAC_BIT_LEVEL_SEL];
            end
            if (trans_done) begin
                level_act_q <= level_sel_q;
            end
            flag_q      <= flag_d;
            inten_q     <= inten_d;
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            irq_q       <= flag_d && inten_d;
            access_error_q <= (wr_fire && wr_drop) || (rd_fire && rd_drop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign awready    = awready_q;
    assign wready     = wready_q;
    assign bvalid     = bvalid_q;
    assign bresp      = bresp_q;
    assign arready    = arready_q;
    assign rvalid     = rvalid_q;
    assign rdata      = rdata_q;
    assign rresp      = rresp_q;
    assign access_error = access_error_q;
    assign irq        = irq_q;
    assign perf_level = level_act_q;
    // one-hot scale bit of the state register
    assign level_busy = state_q[1];

endmodule : plac_top

`default_nettype wire
